// file: include/cpu_decode_pkg.sv
package cpu_decode_pkg;

	// =====================================================================
	// instruction word fields
	localparam int unsigned OPC_HI = 31;
	localparam int unsigned OPC_LO = 26;
	localparam int unsigned FN_HI  = 5;
	localparam int unsigned FN_LO  = 0;
	localparam int unsigned TRF_HI = 20;
	localparam int unsigned TRF_LO = 16;

	// =====================================================================
	// primary opcodes and rows of interest
	localparam logic [5:0] OPC_REG_CLASS    = 6'h00;
	localparam logic [5:0] OPC_BRANCH_TRAP  = 6'h01;
	localparam logic [5:0] OPC_THIRD_COPROC = 6'h13;
	localparam logic [5:0] OPC_PREFETCH     = 6'h33;
	localparam logic [5:0] FN_FLOAT_CMOVE   = 6'h01;
	localparam logic [2:0] ROW_COP_CLASS    = 3'h2;
	localparam logic [2:0] ROW_COP_LOAD     = 3'h6;
	localparam logic [2:0] ROW_COP_STORE    = 3'h7;
	localparam logic [1:0] COP_SYSTEM       = 2'h0;
	localparam logic [1:0] COP_FLOAT        = 2'h1;
	localparam logic [1:0] COP_THIRD        = 2'h3;

	// =====================================================================
	// per-cell level codes: 0 never, 1..4 from that level on,
	// 5 third coproc at 1-2 and a new op at 4, 6 third coproc dword at 2 and
	// a new op from 3, 7 third coproc at 1-2 only
	localparam logic [2:0] LVL_NEVER    = 3'h0;
	localparam logic [2:0] LVL_ONE      = 3'h1;
	localparam logic [2:0] LVL_TWO      = 3'h2;
	localparam logic [2:0] LVL_THREE    = 3'h3;
	localparam logic [2:0] LVL_FOUR     = 3'h4;
	localparam logic [2:0] LVL_C3_OR4   = 3'h5;
	localparam logic [2:0] LVL_C3D_OR3  = 3'h6;
	localparam logic [2:0] LVL_C3_ONLY  = 3'h7;

	// tables list the highest cell first: row 7 col 7 down to row 0 col 0
	localparam logic [63:0][2:0] PRIM_LVL = {
		3'h6, 3'h2, 3'h2, 3'h3, 3'h7, 3'h1, 3'h1, 3'h2,
		3'h6, 3'h2, 3'h2, 3'h3, 3'h5, 3'h1, 3'h1, 3'h2,
		3'h0, 3'h1, 3'h3, 3'h3, 3'h1, 3'h1, 3'h1, 3'h1,
		3'h3, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
		3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h3, 3'h3, 3'h3,
		3'h2, 3'h2, 3'h2, 3'h2, 3'h5, 3'h1, 3'h1, 3'h1,
		3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
		3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1};

	localparam logic [63:0][2:0] REG_LVL = {
		3'h3, 3'h3, 3'h0, 3'h3, 3'h3, 3'h3, 3'h0, 3'h3,
		3'h0, 3'h2, 3'h0, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2,
		3'h3, 3'h3, 3'h3, 3'h3, 3'h1, 3'h1, 3'h0, 3'h0,
		3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
		3'h3, 3'h3, 3'h3, 3'h3, 3'h1, 3'h1, 3'h1, 3'h1,
		3'h3, 3'h3, 3'h0, 3'h3, 3'h1, 3'h1, 3'h1, 3'h1,
		3'h2, 3'h0, 3'h1, 3'h1, 3'h4, 3'h4, 3'h1, 3'h1,
		3'h1, 3'h1, 3'h0, 3'h1, 3'h1, 3'h1, 3'h4, 3'h1};

	localparam logic [31:0][2:0] BT_LVL = {
		3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
		3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h2, 3'h1, 3'h1,
		3'h0, 3'h2, 3'h0, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2,
		3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h2, 3'h1, 3'h1};

	// =====================================================================
	// register map
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_STATUS    = 8'h04;
	localparam logic [7:0] ADDR_EXC_COUNT = 8'h08;
	localparam logic [7:0] ADDR_LAST_WORD = 8'h0c;

	localparam int unsigned CTRL_LVL_LSB   = 0;
	localparam int unsigned CTRL_LVL_MSB   = 2;
	localparam int unsigned CTRL_CU_LSB    = 4;
	localparam int unsigned CTRL_CU_MSB    = 7;
	localparam int unsigned CTRL_COMPAT    = 8;
	localparam logic [2:0]  CTRL_LVL_RST   = 3'h4;
	localparam logic [3:0]  CTRL_CU_RST    = 4'h3;
	localparam logic        CTRL_COMPAT_RST = 1'b0;

	localparam int unsigned CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

	// =====================================================================
	// types
	typedef enum logic [1:0] {
		grp_none,
		grp_primary,
		grp_register,
		grp_branch_trap
	} dec_group_t;

	typedef struct packed {
		logic       valid;
		dec_group_t group;
		logic [5:0] index;
		logic       reserved_exc;
		logic       cop_unusable_exc;
		logic       cop_op;
		logic [1:0] cop_num;
		logic       fpu_route;
		logic       sys_route;
	} dec_result_t;

	typedef struct packed {
		logic [2:0] level;
		logic [3:0] cu_en;
		logic       compat_ii;
	} dec_ctrl_t;

endpackage

// file: logic/cpu_opcode_decoder.sv
// Function
// - primary opcode is bits 31..26, row/column split
// - opcode zero selects register class by function
// - opcode one selects branch/trap group by target field
// - row 010 and rows 110/111 hold coprocessor ops
// - coprocessor 0 class routes as system control
// - float coprocessor words route to the FPU
// - level 4 function 000001 is float conditional move
// - second coprocessor decodes as coprocessor op, no unit
// - third coprocessor ops exist at levels 1-2 only
// - level 4 adds indexed float class and prefetch
// - rows 000/001 jumps, branches and immediate arithmetic
// - row 100 loads, unsigned word load from level 3
// - row 101 stores, doubleword unaligned from level 3
// - level 2 adds likely branches, linked load/store
// - level 3 adds doubleword immediates, loads, stores
// - function rows 000/001 shifts, jumps, sync, moves
// - function rows 010-101 hi/lo, multiply, arithmetic
// - level 3 adds doubleword register-class operations
// - level 2 adds register trap comparisons
// - branch less/greater zero, link and likely forms
// - level 2 adds trap-immediate comparisons
// - reserved encodings raise reserved instruction exception
// - undefined-reserved encodings may raise the exception
// - coprocessor op without access raises unusable exception
// - level-2-only mode refuses third coprocessor ops
module cpu_opcode_decoder
	import cpu_decode_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr_word,
	output dec_result_t      result
);

	// =====================================================================
	// level tests on one table cell
	function automatic logic lvl_ok(input logic [2:0] code, input logic [2:0] lvl);
		logic ok;
		ok = 1'b0;
		case (code)
			LVL_NEVER:   ok = 1'b0;
			LVL_C3_OR4:  ok = (lvl <= LVL_TWO) || (lvl == LVL_FOUR);
			LVL_C3D_OR3: ok = (lvl >= LVL_TWO);
			LVL_C3_ONLY: ok = (lvl <= LVL_TWO);
			default:     ok = (lvl >= code);
		endcase
		return ok;
	endfunction

	function automatic logic third_at(input logic [2:0] code, input logic [2:0] lvl);
		logic t;
		t = 1'b0;
		case (code)
			LVL_C3_OR4:  t = (lvl <= LVL_TWO);
			LVL_C3_ONLY: t = (lvl <= LVL_TWO);
			LVL_C3D_OR3: t = (lvl == LVL_TWO);
			default:     t = 1'b0;
		endcase
		return t;
	endfunction

	// =====================================================================
	// control state
	dec_ctrl_t          ctrl_r;
	dec_result_t        result_r;
	dec_result_t        result_nxt;
	logic [CNT_W-1:0]   ri_count_r;
	logic [CNT_W-1:0]   ri_count_nxt;
	logic [CNT_W-1:0]   cu_count_r;
	logic [CNT_W-1:0]   cu_count_nxt;
	logic [31:0]        last_word_r;
	logic [31:0]        prdata_r;

	// =====================================================================
	// field extraction
	wire logic [5:0] opc      = instr_word[OPC_HI:OPC_LO];
	wire logic [2:0] opc_row  = opc[5:3];
	wire logic [2:0] opc_col  = opc[2:0];
	wire logic [5:0] fn       = instr_word[FN_HI:FN_LO];
	wire logic [4:0] trf      = instr_word[TRF_HI:TRF_LO];
	wire logic [2:0] lvl      = ctrl_r.level;

	wire logic is_reg_class   = (opc == OPC_REG_CLASS);
	wire logic is_branch_trap = (opc == OPC_BRANCH_TRAP);
	wire logic is_prim        = ~is_reg_class & ~is_branch_trap;

	// =====================================================================
	// table lookups, one per group, then the level filter
	wire logic [2:0] prim_code = PRIM_LVL[opc];
	wire logic [2:0] reg_code  = REG_LVL[fn];
	wire logic [2:0] bt_code   = BT_LVL[trf];
	wire logic [2:0] cell_code = is_reg_class   ? reg_code :
	                             is_branch_trap ? bt_code  : prim_code;

	wire logic cell_legal  = lvl_ok(cell_code, lvl);
	wire logic third_op    = is_prim & third_at(prim_code, lvl);
	wire logic compat_drop = third_op & ctrl_r.compat_ii;
	// every unfilled cell raises the exception, the undefined ones included
	wire logic reserved    = ~cell_legal | compat_drop;

	// =====================================================================
	// coprocessor classification
	wire logic row_cop_ls     = (opc_row == ROW_COP_LOAD) || (opc_row == ROW_COP_STORE);
	wire logic class_cell     = (opc_row == ROW_COP_CLASS) & ~opc_col[2];
	wire logic ls_cell        = row_cop_ls & (opc_col[1:0] != 2'h0);
	// column 3 only stays a coprocessor op while the third unit exists
	wire logic col_is_cop     = (opc_col[1:0] != COP_THIRD) | third_op;
	wire logic prim_cop       = is_prim & (class_cell | ls_cell) & col_is_cop;
	wire logic indexed_float  = (opc == OPC_THIRD_COPROC) & (lvl == LVL_FOUR);
	wire logic prefetch_cell  = (opc == OPC_PREFETCH) & (lvl == LVL_FOUR);
	wire logic float_cmove    = is_reg_class & (fn == FN_FLOAT_CMOVE) & (lvl == LVL_FOUR);
	wire logic float_cls      = indexed_float | float_cmove;
	wire logic cop_any        = (prim_cop | float_cls) & ~prefetch_cell & ~reserved;
	wire logic [1:0] cop_num  = float_cls ? COP_FLOAT : opc_col[1:0];
	wire logic cop_denied     = cop_any & ~ctrl_r.cu_en[cop_num];

	// =====================================================================
	// decoded result, combinational
	always_comb begin
		result_nxt = '0;
		if (instr_valid) begin
			result_nxt.valid            = 1'b1;
			result_nxt.group            = is_reg_class   ? grp_register :
			                              is_branch_trap ? grp_branch_trap : grp_primary;
			result_nxt.index            = is_reg_class   ? fn :
			                              is_branch_trap ? {1'b0, trf} : opc;
			result_nxt.reserved_exc     = reserved;
			result_nxt.cop_unusable_exc = cop_denied;
			result_nxt.cop_op           = cop_any;
			result_nxt.cop_num          = cop_any ? cop_num : 2'h0;
			result_nxt.fpu_route        = cop_any & (cop_num == COP_FLOAT);
			result_nxt.sys_route        = cop_any & (cop_num == COP_SYSTEM);
		end
	end

	// =====================================================================
	// bus decode
	wire logic setup_ph  = psel & ~penable;
	wire logic access_ph = psel & penable;
	wire logic hit_ctrl  = (paddr == ADDR_CTRL);
	wire logic hit_stat  = (paddr == ADDR_STATUS);
	wire logic hit_cnt   = (paddr == ADDR_EXC_COUNT);
	wire logic hit_last  = (paddr == ADDR_LAST_WORD);
	wire logic hit_any   = hit_ctrl | hit_stat | hit_cnt | hit_last;
	wire logic wr_ctrl   = access_ph & pwrite & hit_ctrl;
	wire logic wr_cnt    = access_ph & pwrite & hit_cnt;

	wire logic [2:0] wr_level = pwdata[CTRL_LVL_MSB:CTRL_LVL_LSB];
	// a level outside 1..4 would leave the table undefined, so it is not taken
	wire logic       wr_level_ok = (wr_level >= LVL_ONE) && (wr_level <= LVL_FOUR);

	wire logic [31:0] ctrl_word = {23'h0, ctrl_r.compat_ii, ctrl_r.cu_en, 1'b0, ctrl_r.level};
	wire logic [31:0] stat_word = {16'h0, result_r};
	wire logic [31:0] cnt_word  = {cu_count_r, ri_count_r};
	wire logic [31:0] rd_mux    = hit_ctrl ? ctrl_word :
	                              hit_stat ? stat_word :
	                              hit_cnt  ? cnt_word  :
	                              hit_last ? last_word_r : 32'h0;

	assign pready  = access_ph;
	assign pslverr = access_ph & ~hit_any;
	assign prdata  = prdata_r;
	assign result  = result_r;

	// =====================================================================
	// event counters: a new event in a clearing cycle still counts
	always_comb begin
		ri_count_nxt = wr_cnt ? '0 : ri_count_r;
		cu_count_nxt = wr_cnt ? '0 : cu_count_r;
		if (result_nxt.reserved_exc && ri_count_nxt != CNT_MAX) begin
			ri_count_nxt = ri_count_nxt + 1'b1;
		end
		if (result_nxt.cop_unusable_exc && cu_count_nxt != CNT_MAX) begin
			cu_count_nxt = cu_count_nxt + 1'b1;
		end
	end

	// =====================================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r.level     <= CTRL_LVL_RST;
			ctrl_r.cu_en     <= CTRL_CU_RST;
			ctrl_r.compat_ii <= CTRL_COMPAT_RST;
		end else if (wr_ctrl) begin
			if (wr_level_ok) begin
				ctrl_r.level <= wr_level;
			end
			ctrl_r.cu_en     <= pwdata[CTRL_CU_MSB:CTRL_CU_LSB];
			ctrl_r.compat_ii <= pwdata[CTRL_COMPAT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_r   <= '0;
			ri_count_r <= '0;
			cu_count_r <= '0;
		end else begin
			result_r   <= result_nxt;
			ri_count_r <= ri_count_nxt;
			cu_count_r <= cu_count_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_word_r <= 32'h0;
		end else if (instr_valid) begin
			last_word_r <= instr_word;
		end
	end

	// read data is caught in the setup cycle so the access needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0;
		end else if (setup_ph) begin
			prdata_r <= rd_mux;
		end
	end

endmodule // cpu_opcode_decoder

// file: sim/fetch_model.sv
module fetch_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        go,
	input  wire logic [31:0] word,
	output logic             instr_valid,
	output logic [31:0]      instr_word
);
	timeunit 1ns;
	timeprecision 1ps;
	// =========================================
	// fetch stage
	// idle cycles invert the held word each cycle, so the last word and its inverse alternate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_valid <= 1'b0;
			instr_word  <= 32'h0;
		end else begin
			instr_valid <= go;
			instr_word  <= go ? word : ~instr_word;
		end
	end
endmodule // fetch_model

// file: sim/decoder_checker_sva.sv
module decoder_checker
	import cpu_decode_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        instr_valid,
	input wire logic [31:0] instr_word,
	input wire dec_result_t result
);
	timeunit 1ns;
	timeprecision 1ps;
	// =========================================
	// mirror of level and access enables
	logic [2:0] lvl_r;
	logic [3:0] cu_r;
	logic [3:0] cu_q_r;
	wire        ctl_wr = psel && penable && pwrite && paddr == ADDR_CTRL;
	wire        lvl_ok = pwdata[2:0] >= 3'h1 && pwdata[2:0] <= 3'h4;
	wire  [5:0] opc    = instr_word[31:26];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl_r  <= CTRL_LVL_RST;
			cu_r   <= CTRL_CU_RST;
			cu_q_r <= CTRL_CU_RST;
		end else begin
			cu_q_r <= cu_r;
			if (ctl_wr) begin
				cu_r <= pwdata[7:4];
				if (lvl_ok)
					lvl_r <= pwdata[2:0];
			end
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// =========================================
	// properties
	property p_latency; instr_valid |=> result.valid; endproperty
	property p_idle; !instr_valid |=> result == '0; endproperty
	property p_reg; instr_valid && opc == OPC_REG_CLASS |=>
		result.group == grp_register && result.index == $past(instr_word[5:0]); endproperty
	property p_bt; instr_valid && opc == OPC_BRANCH_TRAP |=>
		result.group == grp_branch_trap && result.index == {1'b0, $past(instr_word[20:16])}; endproperty
	property p_prim; instr_valid && opc > 6'h01 |=> result.group == grp_primary && result.index == $past(opc); endproperty
	property p_sys; instr_valid && opc == 6'h10 |=>
		result.sys_route && result.cop_op && result.cop_num == COP_SYSTEM && !result.reserved_exc; endproperty
	property p_fpu; instr_valid && opc == 6'h11 |=> result.fpu_route && result.cop_num == COP_FLOAT; endproperty
	property p_unus; result.valid |-> result.cop_unusable_exc == (result.cop_op && !cu_q_r[result.cop_num]); endproperty
	property p_third; instr_valid && lvl_r >= 3'h3 && (opc == OPC_THIRD_COPROC || opc == 6'h3b) |=>
		!(result.cop_op && result.cop_num == COP_THIRD); endproperty
	property p_cmove; instr_valid && lvl_r == 3'h4 && opc == 6'h00 && instr_word[5:0] == FN_FLOAT_CMOVE |=>
		result.fpu_route && !result.reserved_exc; endproperty
	a_latency: assert property (p_latency) else $error("no result after word");
	a_idle: assert property (p_idle) else $error("result not cleared");
	a_reg: assert property (p_reg) else $error("register class wrong");
	a_bt: assert property (p_bt) else $error("branch trap group wrong");
	a_prim: assert property (p_prim) else $error("primary opcode wrong");
	a_sys: assert property (p_sys) else $error("system class wrong");
	a_fpu: assert property (p_fpu) else $error("float class wrong");
	a_unus: assert property (p_unus) else $error("unusable flag wrong");
	a_third: assert property (p_third) else $error("third coproc above level 2");
	a_cmove: assert property (p_cmove) else $error("float cond move wrong");
	c_second_coproc_class: cover property (result.cop_op && result.cop_num == 2'h2);
	c_rsv: cover property (result.reserved_exc);
	c_wr: cover property (ctl_wr);
endmodule // decoder_checker

bind cpu_opcode_decoder decoder_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.instr_valid(instr_valid), .instr_word(instr_word), .result(result));

// file: sim/testbench.sv
module testbench
	import cpu_decode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, pready, pslverr, er;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, wreq = 32'h0, prdata, rd;
	logic        instr_valid;
	logic [31:0] instr_word;
	logic [8:0]  ctl_cur = 9'h034;
	dec_result_t result;
	int          failures = 0, checks = 0;
	always #10 pclk = ~pclk;
	fetch_model i_fetch (.pclk(pclk), .presetn(presetn), .go(go), .word(wreq), .instr_valid(instr_valid),
		.instr_word(instr_word));
	cpu_opcode_decoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instr_valid(instr_valid), .instr_word(instr_word), .result(result));
	// =========================================
	// shared helpers
	function automatic logic [31:0] op(input logic [5:0] c); return {c, 26'h3ffffff}; endfunction
	function automatic logic [31:0] fn(input logic [5:0] c); return {6'h00, 20'hfffff, c}; endfunction
	function automatic logic [31:0] rt(input logic [4:0] c); return {6'h01, 5'h1f, c, 16'hffff}; endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// a slave that never answers counts as a mismatch
		if (pready !== 1'b1) begin
			failures++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// e packs reserved, coproc op, coproc number, float route, system route
	task automatic dec(input logic [8:0] ctl, input logic [31:0] w, input logic [5:0] e);
		dec_result_t x;
		if (ctl !== ctl_cur) begin
			apb(1'b1, ADDR_CTRL, {23'h0, ctl});
			ctl_cur = ctl;
		end
		x = '0;
		x.valid = 1'b1;
		x.group = w[31:26] == 6'h00 ? grp_register : w[31:26] == 6'h01 ? grp_branch_trap : grp_primary;
		x.index = w[31:26] == 6'h00 ? w[5:0] : w[31:26] == 6'h01 ? {1'b0, w[20:16]} : w[31:26];
		{x.reserved_exc, x.cop_op, x.cop_num, x.fpu_route, x.sys_route} = e;
		x.cop_unusable_exc = x.cop_op & ~ctl[4 + x.cop_num];
		@(posedge pclk);
		go <= 1'b1;
		wreq <= w;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		#1 cmp(32'(result), 32'(x));
	endtask
	// =========================================
	// scenarios
	task automatic t_regs;
		apb(1'b0, ADDR_CTRL, 32'h0);
		cmp(rd, 32'h34);
		apb(1'b1, 8'h10, 32'h0);
		cmp(32'(er), 32'h1);
	endtask
	task automatic t_count;
		apb(1'b1, ADDR_EXC_COUNT, 32'h0);
		dec(9'h034, fn(6'h05), 6'h20);
		apb(1'b0, ADDR_EXC_COUNT, 32'h0);
		cmp(rd, 32'h00000001);
		dec(9'h034, op(6'h12), 6'h18);
		apb(1'b0, ADDR_EXC_COUNT, 32'h0);
		cmp(rd, 32'h00010001);
		apb(1'b0, ADDR_LAST_WORD, 32'h0);
		cmp(rd, op(6'h12));
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp(rd, 32'h0);
		cmp(32'(er), 32'h0);
	endtask
	task automatic t_coproc;
		dec(9'h034, op(6'h10), 6'h11);
		dec(9'h034, op(6'h11), 6'h16);
		dec(9'h034, op(6'h12), 6'h18);
		dec(9'h034, op(6'h31), 6'h16);
		dec(9'h034, op(6'h3a), 6'h18);
		dec(9'h034, op(6'h13), 6'h16);
		dec(9'h034, op(6'h33), 6'h00);
		dec(9'h034, fn(6'h01), 6'h16);
		dec(9'h0f4, op(6'h12), 6'h18);
	endtask
	task automatic t_plain;
		dec(9'h034, op(6'h02), 6'h00);
		dec(9'h034, op(6'h0f), 6'h00);
		dec(9'h034, op(6'h2f), 6'h20);
		dec(9'h034, op(6'h2c), 6'h00);
		dec(9'h034, op(6'h1c), 6'h20);
		dec(9'h034, fn(6'h05), 6'h20);
		dec(9'h034, fn(6'h20), 6'h00);
		dec(9'h034, fn(6'h2c), 6'h00);
		dec(9'h034, rt(5'h10), 6'h00);
		dec(9'h034, rt(5'h1f), 6'h20);
		dec(9'h034, op(6'h3c), 6'h00);
	endtask
	task automatic t_levels;
		dec(9'h033, op(6'h13), 6'h20);
		dec(9'h033, op(6'h33), 6'h20);
		dec(9'h033, fn(6'h01), 6'h20);
		dec(9'h033, op(6'h27), 6'h00);
		dec(9'h033, op(6'h37), 6'h00);
		dec(9'h033, fn(6'h0a), 6'h20);
		dec(9'h032, op(6'h13), 6'h1c);
		dec(9'h032, op(6'h37), 6'h1c);
		dec(9'h032, op(6'h27), 6'h20);
		dec(9'h032, fn(6'h3c), 6'h20);
		dec(9'h032, op(6'h18), 6'h20);
		dec(9'h032, op(6'h14), 6'h00);
		dec(9'h032, fn(6'h30), 6'h00);
		dec(9'h032, rt(5'h02), 6'h00);
		dec(9'h032, rt(5'h0c), 6'h00);
		dec(9'h031, op(6'h14), 6'h20);
		dec(9'h031, fn(6'h30), 6'h20);
		dec(9'h031, rt(5'h0c), 6'h20);
		dec(9'h031, op(6'h35), 6'h20);
		dec(9'h031, fn(6'h0f), 6'h20);
	endtask
	task automatic t_compat;
		dec(9'h132, op(6'h13), 6'h20);
		dec(9'h132, op(6'h3b), 6'h20);
		dec(9'h132, op(6'h14), 6'h00);
	endtask
	task automatic results;
		if (failures == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_coproc();
		t_plain();
		t_levels();
		t_compat();
		t_count();
		results();
	end
	initial begin
		#100000;
		failures++;
		results();
	end
endmodule // testbench
